// >>> remote_terminal.sv
// Far-side byte sink standing for the remote terminal on one serial port.
// Assumes a valid/ready byte stream from the formatter, all on clk.
`timescale 1ns/1ps
module remote_terminal
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Byte stream from the formatter
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  output logic rx_ready,
  // Pacing controls from the bench
  input wire logic hold,
  input wire logic slow
);
  // Bytes accepted so far, read back by the bench at the end of a scenario
  int n_taken;

  // Ready changes only after a rising edge; a slow terminal takes one byte in four cycles
  // on average, so the formatter must keep its byte standing while it waits
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_ready <= 1'b0;
      n_taken <= 0;
    end
    else
    begin
      rx_ready <= !hold && (!slow || ($urandom_range(3) == 0));
      if (rx_valid && rx_ready)
        n_taken <= n_taken + 1;
    end
  end
endmodule

// >>> serial_transmit_formatter.sv
// Message formatter feeding two serial byte streams, scan paced.
// Assumes scan_tick marks each end of program scan and inputs are synchronous.
`timescale 1ns/1ps
module serial_transmit_formatter
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Scan pacing and instruction starts
  input wire logic scan_tick,
  input wire logic in_interrupt,
  input wire logic port_one_transmit_instr,
  input wire logic port_two_transmit_instr,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic we,
  input wire logic re,
  output logic [31:0] rdata,
  // Serial port one byte stream
  output logic [7:0] tx_one_data,
  output logic tx_one_valid,
  input wire logic tx_one_ready,
  // Serial port two byte stream
  output logic [7:0] tx_two_data,
  output logic tx_two_valid,
  input wire logic tx_two_ready,
  // Flags
  output logic completion_flag_one,
  output logic completion_flag_two,
  output logic exec_error_relay,
  output logic error_indicator
);
  // Whole control state in one record
  typedef struct packed {
    stf_pkg::state_t st;
    logic port; // Port being served, 0 is port one
    logic [4:0] ep; // Element pointer
    logic [2:0] dg; // Digit index inside element
    logic [6:0] rp; // Repeat index
    logic [1:0][2:0] pend;
    logic [1:0][15:0] stat;
    logic [1:0][15:0] cnt;
    logic [1:0] done;
    logic [7:0] xacc;
    logic [15:0] aacc;
    logic [15:0] crc;
    logic [7:0] lrc;
    logic nhi; // A high nibble is held for the LRC pair
    logic [3:0] nib;
    logic [1:0] gap;
    logic [9:0] ctrl;
    logic err;
    logic ov;
    logic [7:0] ob;
    logic [31:0] rd;
  } state_rec_t;
  state_rec_t r_r, r_nxt;
  // Memories written only by software
  logic [31:0] prog_mem [0:31];
  logic [15:0] data_mem [0:63];
  // Combinational helpers
  logic [31:0] el;
  logic [15:0] wv;
  logic [1:0] kind;
  logic [2:0] ndig;
  logic [6:0] nrep;
  logic [7:0] byte_v;
  logic [15:0] bccv;
  logic [15:0] posn;
  logic last_dig, last_rep, stop, rdy, take;
  logic [1:0] req;
  // Uppercase hex character
  function automatic logic [7:0] hex_char(input logic [3:0] v);
    hex_char = (v < 4'hA) ? (8'h30 + {4'h0, v}) : (8'h37 + {4'h0, v});
  endfunction
  // Character back to nibble, for the Modbus ASCII pair sum
  function automatic logic [3:0] hex_val(input logic [7:0] c);
    hex_val = (c >= 8'h41) ? 4'((c - 8'h37)) : c[3:0];
  endfunction
  // Binary to decimal digits by shift and add three
  function automatic logic [19:0] dabble(input logic [15:0] v);
    logic [35:0] s;
    s = {20'h00000, v};
    for (int i = 0; i < 16; i++)
    begin
      for (int d = 0; d < 5; d++)
        if (s[16 + 4 * d +: 4] > 4'h4)
          s[16 + 4 * d +: 4] = s[16 + 4 * d +: 4] + 4'h3;
      s = {s[34:0], 1'b0};
    end
    dabble = s[35:16];
  endfunction
  // One byte of the Modbus RTU check
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] x;
    x = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
      x = x[0] ? ((x >> 1) ^ stf_pkg::CRC_POLY) : (x >> 1);
    crc_step = x;
  endfunction
  // Element decode and byte generation
  always_comb
  begin
    el = prog_mem[r_r.ep];
    kind = el[stf_pkg::F_KIND +: 2];
    wv = data_mem[6'(el[5:0] + r_r.rp[5:0])];
    nrep = (el[stf_pkg::F_REP +: 7] == 7'h00) ? 7'h01 : el[stf_pkg::F_REP +: 7];
    ndig = (kind == stf_pkg::K_CONST) ? 3'h1 : el[stf_pkg::F_DIG +: 3];
    if (ndig == 3'h0)
      ndig = 3'h1;
    case (r_r.ctrl[stf_pkg::C_BCCF +: 3])
      stf_pkg::B_XOR: bccv = {8'h00, r_r.xacc};
      stf_pkg::B_ADD: bccv = r_r.aacc;
      stf_pkg::B_ADD2: bccv = 16'(-r_r.aacc);
      stf_pkg::B_MASC: bccv = {8'h00, 8'(-r_r.lrc)};
      default: bccv = r_r.crc;
    endcase
    byte_v = 8'h00;
    if (kind == stf_pkg::K_CONST)
    begin
      // Constant goes out as is, trimmed to the port's data bits
      byte_v = r_r.ctrl[stf_pkg::C_EIGHT + r_r.port] ? el[7:0] : (el[7:0] & stf_pkg::MASK7);
    end
    else if (kind == stf_pkg::K_WORD)
    begin
      // Most significant selected digit first, low digits kept
      case (el[stf_pkg::F_CONV +: 2])
        stf_pkg::CV_BIN: byte_v = hex_char(4'(wv >> (4 * (ndig - 3'h1 - r_r.dg))));
        stf_pkg::CV_BCD: byte_v = hex_char(4'(dabble(wv) >> (4 * (ndig - 3'h1 - r_r.dg))));
        default: byte_v = (ndig > 3'h1 && r_r.dg == 3'h0) ? wv[15:8] : wv[7:0];
      endcase
    end
    else if (kind == stf_pkg::K_BCC)
    begin
      // RTU check without hex conversion goes low byte first, the rest high digit first
      if (el[stf_pkg::F_CONV +: 2] == stf_pkg::CV_BIN)
        byte_v = hex_char(4'(bccv >> (4 * (ndig - 3'h1 - r_r.dg))));
      else if (r_r.ctrl[stf_pkg::C_BCCF +: 3] == stf_pkg::B_MRTU)
        byte_v = (r_r.dg == 3'h0) ? bccv[7:0] : bccv[15:8];
      else
        byte_v = (ndig > 3'h1 && r_r.dg == 3'h0) ? bccv[15:8] : bccv[7:0];
    end
    last_dig = (r_r.dg == ndig - 3'h1);
    last_rep = (kind != stf_pkg::K_WORD) || (r_r.rp == nrep - 7'h01);
    // Message ends at end marker or byte ceiling; the element pointer wraps after the last slot
    stop = (kind == stf_pkg::K_END) || (r_r.cnt[r_r.port] >= stf_pkg::MAX_BYTES);
    rdy = r_r.port ? tx_two_ready : tx_one_ready;
    take = (r_r.st == stf_pkg::S_SEND) && !r_r.ov && !stop;
    posn = r_r.cnt[r_r.port] + 16'h0001;
  end
  // Start requests sampled at the scan boundary, outside interrupts
  assign req = (scan_tick && !in_interrupt) ?
               {port_two_transmit_instr, port_one_transmit_instr} : 2'b00;
  // Next state
  always_comb
  begin
    r_nxt = r_r;
    r_nxt.rd = 32'h00000000;
    // Register writes
    if (we && addr == stf_pkg::A_CTRL)
      r_nxt.ctrl = wdata[9:0];
    if (we && addr == stf_pkg::A_CTRL && wdata[stf_pkg::C_ERRCLR])
      r_nxt.err = 1'b0;
    // Interrupt-context start is refused and flagged; set beats clear
    if (scan_tick && in_interrupt && (port_one_transmit_instr || port_two_transmit_instr))
      r_nxt.err = 1'b1;
    r_nxt.ctrl[stf_pkg::C_ERRCLR] = 1'b0;
    // Slot bookkeeping per port
    for (int p = 0; p < 2; p++)
    begin
      if (req[p])
      begin
        if (r_r.pend[p] < stf_pkg::SLOTS)
        begin
          r_nxt.pend[p] = r_r.pend[p] + 3'h1;
          if (!(r_r.st != stf_pkg::S_IDLE && r_r.port == 1'(p)))
          begin
            r_nxt.stat[p] = stf_pkg::ST_PREP;
            r_nxt.done[p] = 1'b0;
          end
        end
        else
          r_nxt.stat[p] = stf_pkg::ST_ERR_SLOT;
      end
    end
    // Output byte leaves on handshake
    if (r_r.ov && rdy)
      r_nxt.ov = 1'b0;
    case (r_r.st)
      stf_pkg::S_IDLE:
      begin
        // Port one has priority when both are queued
        if (r_r.pend[0] != 3'h0 || r_r.pend[1] != 3'h0)
        begin
          r_nxt.port = (r_r.pend[0] == 3'h0);
          r_nxt.pend[r_nxt.port] = r_nxt.pend[r_nxt.port] - 3'h1;
          r_nxt.cnt[r_nxt.port] = 16'h0000;
          r_nxt.ep = 5'h00;
          r_nxt.dg = 3'h0;
          r_nxt.rp = 7'h00;
          r_nxt.xacc = 8'h00;
          r_nxt.aacc = 16'h0000;
          r_nxt.crc = stf_pkg::CRC_INIT;
          r_nxt.lrc = 8'h00;
          r_nxt.nhi = 1'b0;
          r_nxt.st = stf_pkg::S_PREP;
        end
      end
      stf_pkg::S_PREP:
      begin
        // Transmission is enabled at the next scan end
        if (scan_tick)
        begin
          r_nxt.st = stf_pkg::S_SEND;
          r_nxt.stat[r_r.port] = stf_pkg::ST_SEND;
        end
      end
      stf_pkg::S_SEND:
      begin
        if (!r_r.ov && stop)
        begin
          r_nxt.st = stf_pkg::S_POST;
          r_nxt.stat[r_r.port] = stf_pkg::ST_POST;
        end
        else if (take)
        begin
          r_nxt.ov = 1'b1;
          r_nxt.ob = byte_v;
          r_nxt.cnt[r_r.port] = posn;
          // Check covers data bytes from the chosen position on
          if (kind != stf_pkg::K_BCC && posn >= {12'h000, r_r.ctrl[stf_pkg::C_BCCPOS +: 4]})
          begin
            r_nxt.xacc = r_r.xacc ^ byte_v;
            r_nxt.aacc = r_r.aacc + {8'h00, byte_v};
            r_nxt.crc = crc_step(r_r.crc, byte_v);
            r_nxt.nhi = !r_r.nhi;
            if (!r_r.nhi)
              r_nxt.nib = hex_val(byte_v);
            else
              r_nxt.lrc = r_r.lrc + {r_r.nib, hex_val(byte_v)};
          end
          // Advance digit, repeat, element
          if (!last_dig)
            r_nxt.dg = r_r.dg + 3'h1;
          else
          begin
            r_nxt.dg = 3'h0;
            if (!last_rep)
              r_nxt.rp = r_r.rp + 7'h01;
            else
            begin
              r_nxt.rp = 7'h00;
              r_nxt.ep = r_r.ep + 5'h01;
            end
          end
        end
      end
      stf_pkg::S_POST:
      begin
        // End processing at scan end completes the instruction
        if (scan_tick)
        begin
          r_nxt.st = stf_pkg::S_GAP;
          r_nxt.gap = stf_pkg::GAP_SCANS;
          r_nxt.stat[r_r.port] = stf_pkg::ST_DONE;
          r_nxt.done[r_r.port] = 1'b1;
        end
      end
      stf_pkg::S_GAP:
      begin
        // Queued work waits two scans after completion
        if (scan_tick)
        begin
          r_nxt.gap = r_r.gap - 2'h1;
          if (r_r.gap == 2'h1)
            r_nxt.st = stf_pkg::S_IDLE;
        end
      end
      default: r_nxt.st = stf_pkg::S_IDLE;
    endcase
    // Read data stands in the cycle after the strobe
    if (re)
    begin
      case (addr)
        stf_pkg::A_CTRL: r_nxt.rd = {22'h0, r_r.ctrl};
        stf_pkg::A_STAT1: r_nxt.rd = {16'h0000, r_r.stat[0]};
        stf_pkg::A_CNT1: r_nxt.rd = {16'h0000, r_r.cnt[0]};
        stf_pkg::A_STAT2: r_nxt.rd = {16'h0000, r_r.stat[1]};
        stf_pkg::A_CNT2: r_nxt.rd = {16'h0000, r_r.cnt[1]};
        stf_pkg::A_ERR: r_nxt.rd = {31'h0, r_r.err};
        default:
        begin
          if (addr[7:6] == stf_pkg::A_DATA_PAGE)
            r_nxt.rd = {16'h0000, data_mem[addr[5:0]]};
          else if (addr[7:5] == stf_pkg::A_PROG_PAGE)
            r_nxt.rd = prog_mem[addr[4:0]];
        end
      endcase
    end
  end
  // State register
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      r_r <= '0;
      r_r.st <= stf_pkg::S_IDLE;
      r_r.ctrl <= stf_pkg::CTRL_RESET;
    end
    else
      r_r <= r_nxt;
  end
  // Memories take no reset; software loads them before any start
  always_ff @(posedge clk)
  begin
    if (we && addr[7:6] == stf_pkg::A_DATA_PAGE)
      data_mem[addr[5:0]] <= wdata[15:0];
    if (we && addr[7:5] == stf_pkg::A_PROG_PAGE)
      prog_mem[addr[4:0]] <= wdata;
  end
  // Outputs
  assign rdata = r_r.rd;
  assign tx_one_data = r_r.ob;
  assign tx_two_data = r_r.ob;
  assign tx_one_valid = r_r.ov && !r_r.port;
  assign tx_two_valid = r_r.ov && r_r.port;
  assign completion_flag_one = r_r.done[0];
  assign completion_flag_two = r_r.done[1];
  assign exec_error_relay = r_r.err;
  assign error_indicator = r_r.err;
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  AST_ONE_PORT: assert property (!(tx_one_valid && tx_two_valid))
    else $error("both ports drive a byte");
  AST_BYTE_CEILING: assert property (r_r.cnt[0] <= stf_pkg::MAX_BYTES)
    else $error("port one byte count above ceiling");
  AST_DONE_STATUS: assert property ($rose(completion_flag_one) |->
    r_r.stat[0] == stf_pkg::ST_DONE && $past(r_r.st) == stf_pkg::S_POST)
    else $error("completion without status 64");
  AST_INTR_ERR: assert property (scan_tick && in_interrupt && port_one_transmit_instr
    |=> exec_error_relay && error_indicator && r_r.pend[0] <= $past(r_r.pend[0]))
    else $error("interrupt start not flagged");
  AST_SLOT_LIMIT: assert property (r_r.pend[0] <= stf_pkg::SLOTS)
    else $error("too many pending slots");
  AST_SLOT_ERR: assert property (req[0] && r_r.pend[0] == stf_pkg::SLOTS
    |=> r_r.stat[0] == stf_pkg::ST_ERR_SLOT)
    else $error("overflow start missed error code");
  AST_GAP_SCANS: assert property ($fell(r_r.st == stf_pkg::S_GAP) |->
    $past(scan_tick) && $past(r_r.gap) == 2'h1)
    else $error("next instruction too early");
  AST_SEND_STATUS: assert property (r_r.st == stf_pkg::S_PREP && scan_tick
    |=> r_r.stat[r_r.port] == stf_pkg::ST_SEND ##0 r_r.st == stf_pkg::S_SEND)
    else $error("send status not entered");
  AST_COUNT_STEP: assert property ($rose(r_r.ov) |->
    r_r.cnt[r_r.port] == $past(r_r.cnt[r_r.port]) + 16'h0001)
    else $error("byte not counted");
  COV_ONE_DONE: cover property ($rose(completion_flag_one));
  COV_TWO_DONE: cover property ($rose(completion_flag_two));
  COV_SLOT_ERR: cover property (r_r.stat[0] == stf_pkg::ST_ERR_SLOT);
  COV_BCC_SENT: cover property (take && kind == stf_pkg::K_BCC);
endmodule

// >>> stf_pkg.sv
// Constants, field layouts and state encodings for the serial transmit formatter.
// Assumes one clock domain and a plain register port with one-cycle strobes.
// Behaviour
// - Port one start sends formatted message.
// - Port two start sends on port two.
// - At most 200 message bytes per instruction.
// - Completion flag set when sequence ends.
// - Status word then sent-byte count word.
// - Start inside interrupt raises execution error.
// - Five pending slots per port.
// - Excess start gets error code, no run.
// - Queued start begins two scans after completion.
// - Held start re-executes every scan.
// - Constant element sends one unchanged byte.
// - Constant masked to seven or eight bits.
// - Word sent in chosen conversion and digits.
// - Repeat sends consecutive words, up to 99; the seven-bit repeat field takes counts up to 127.
// - Optional check character, five formulas.
// - Check covers start position to preceding byte.
// - Status steps 16, 32, 48, 64.
// - Sent count includes check bytes.
package stf_pkg;
  // Register indices on the plain port
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STAT1 = 8'h01;
  localparam logic [7:0] A_CNT1 = 8'h02;
  localparam logic [7:0] A_STAT2 = 8'h03;
  localparam logic [7:0] A_CNT2 = 8'h04;
  localparam logic [7:0] A_ERR = 8'h05;
  localparam logic [1:0] A_DATA_PAGE = 2'h1; // 0x40..0x7F data words
  localparam logic [2:0] A_PROG_PAGE = 3'h4; // 0x80..0x9F message elements
  // Control register fields
  localparam int C_EIGHT = 0; // Two bits, one per port
  localparam int C_ERRCLR = 2;
  localparam int C_BCCPOS = 3; // Four bits
  localparam int C_BCCF = 7; // Three bits
  localparam logic [9:0] CTRL_RESET = 10'h008;
  // Element fields
  localparam int F_KIND = 30;
  localparam int F_CONV = 28;
  localparam int F_DIG = 25;
  localparam int F_REP = 18;
  localparam logic [1:0] K_CONST = 2'h0;
  localparam logic [1:0] K_WORD = 2'h1;
  localparam logic [1:0] K_BCC = 2'h2;
  localparam logic [1:0] K_END = 2'h3;
  localparam logic [1:0] CV_NONE = 2'h0;
  localparam logic [1:0] CV_BIN = 2'h1;
  localparam logic [1:0] CV_BCD = 2'h2;
  localparam logic [2:0] B_XOR = 3'h0;
  localparam logic [2:0] B_ADD = 3'h1;
  localparam logic [2:0] B_ADD2 = 3'h2;
  localparam logic [2:0] B_MASC = 3'h3;
  localparam logic [2:0] B_MRTU = 3'h4;
  localparam logic [15:0] CRC_POLY = 16'hA001;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [7:0] MASK7 = 8'h7F;
  // Limits and status codes
  localparam logic [15:0] MAX_BYTES = 16'h00C8;
  localparam logic [2:0] SLOTS = 3'h5;
  localparam logic [1:0] GAP_SCANS = 2'h2;
  localparam logic [15:0] ST_PREP = 16'h0010;
  localparam logic [15:0] ST_SEND = 16'h0020;
  localparam logic [15:0] ST_POST = 16'h0030;
  localparam logic [15:0] ST_DONE = 16'h0040;
  localparam logic [15:0] ST_ERR_SLOT = 16'h0101;
  typedef enum logic [2:0] {S_IDLE, S_PREP, S_SEND, S_POST, S_GAP} state_t;
endpackage

// >>> tb_serial_transmit_formatter.sv
// Self-checking bench for the serial transmit formatter with a terminal on each port.
// Assumes the register map and scan pacing given in the formatter package.
`timescale 1ns/1ps
module tb_serial_transmit_formatter;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic scan_tick = 1'b0;
  logic in_interrupt = 1'b0;
  logic port_one_transmit_instr = 1'b0;
  logic port_two_transmit_instr = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic we = 1'b0;
  logic re = 1'b0;
  logic re_d = 1'b0;
  logic [31:0] rdata;
  logic [7:0] tx_one_data, tx_two_data;
  logic tx_one_valid, tx_two_valid, tx_one_ready, tx_two_ready;
  logic completion_flag_one, completion_flag_two, exec_error_relay, error_indicator;
  logic hold_one = 1'b0; // Stalls terminal one completely
  logic [7:0] m[$]; // Message being built
  logic [7:0] q1[$], q2[$]; // Expected bytes per port
  logic [31:0] rq[$]; // Expected read data
  int n_mismatch = 0;
  int n_compared = 0;
  int k;
  logic [31:0] rnd; // Random word for the long message, kept off the bus signals

  always #4 clk = ~clk;

  serial_transmit_formatter serial_transmit_formatter_inst (.clk(clk), .rst_b(rst_b),
    .scan_tick(scan_tick), .in_interrupt(in_interrupt),
    .port_one_transmit_instr(port_one_transmit_instr),
    .port_two_transmit_instr(port_two_transmit_instr), .addr(addr), .wdata(wdata),
    .we(we), .re(re), .rdata(rdata), .tx_one_data(tx_one_data), .tx_one_valid(tx_one_valid),
    .tx_one_ready(tx_one_ready), .tx_two_data(tx_two_data), .tx_two_valid(tx_two_valid),
    .tx_two_ready(tx_two_ready), .completion_flag_one(completion_flag_one),
    .completion_flag_two(completion_flag_two), .exec_error_relay(exec_error_relay),
    .error_indicator(error_indicator));
  remote_terminal remote_terminal_inst (.clk(clk), .rst_b(rst_b), .rx_data(tx_one_data),
    .rx_valid(tx_one_valid), .rx_ready(tx_one_ready), .hold(hold_one), .slow(1'b1));
  remote_terminal remote_terminal_two_inst (.clk(clk), .rst_b(rst_b), .rx_data(tx_two_data),
    .rx_valid(tx_two_valid), .rx_ready(tx_two_ready), .hold(1'b0), .slow(1'b0));

  // Single comparison point
  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("BAD %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task conclude;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watcher: read data stand only in the cycle after the strobe; bytes on each handshake
  always @(posedge clk)
  begin
    if (re_d)
      check(rdata, rq.pop_front());
    re_d <= re;
    if (tx_one_valid === 1'b1 && tx_one_ready === 1'b1)
      check({24'h0, tx_one_data}, q1.size() > 0 ? {24'h0, q1.pop_front()} : 32'hFFFF);
    if (tx_two_valid === 1'b1 && tx_two_ready === 1'b1)
      check({24'h0, tx_two_data}, q2.size() > 0 ? {24'h0, q2.pop_front()} : 32'hFFFF);
  end

  // Bus cycles: one strobe cycle, then an idle cycle
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    rq.push_back(e);
    @(posedge clk);
    re <= 1'b0;
  endtask

  // One scan end with the given start and interrupt levels, then a gap
  task tick(input logic s1, input logic s2, input logic irq, input int gap);
    @(posedge clk);
    scan_tick <= 1'b1;
    port_one_transmit_instr <= s1;
    port_two_transmit_instr <= s2;
    in_interrupt <= irq;
    @(posedge clk);
    scan_tick <= 1'b0;
    port_one_transmit_instr <= 1'b0;
    port_two_transmit_instr <= 1'b0;
    in_interrupt <= 1'b0;
    repeat (gap) @(posedge clk);
  endtask

  // Keep scanning until the port's completion flag is high, bounded
  task wait_flag(input logic two);
    for (k = 0; k < 100; k++)
    begin
      if ((two ? completion_flag_two : completion_flag_one) === 1'b1)
        break;
      tick(1'b0, 1'b0, 1'b0, 20);
    end
    check({31'h0, two ? completion_flag_two : completion_flag_one}, 32'h1);
  endtask

  function logic [31:0] el(input logic [1:0] kd, input logic [1:0] cv, input logic [2:0] dg,
                           input logic [6:0] rp, input logic [7:0] lo);
    return {kd, cv, dg, rp, 10'h000, lo};
  endfunction

  function logic [7:0] hexch(input logic [15:0] v);
    return (v[3:0] < 4'hA) ? 8'h30 + v[3:0] : 8'h37 + v[3:0];
  endfunction

  function logic [7:0] nib(input logic [7:0] x);
    return (x >= 8'h41) ? x - 8'h37 : x - 8'h30;
  endfunction

  // Expected digits of one word, most significant first, low digits kept
  task add_word(input logic [15:0] v, input logic [1:0] cv, input int dg);
    int i;
    for (i = dg - 1; i >= 0; i--)
    begin
      if (cv == stf_pkg::CV_BIN)
        m.push_back(hexch(v >> (4 * i)));
      else if (cv == stf_pkg::CV_BCD)
        m.push_back(8'h30 + 8'((int'(v) / (10 ** i)) % 10));
      else
        m.push_back(i == 1 ? v[15:8] : v[7:0]);
    end
  endtask

  // Expected check bytes over the message from the start position onwards
  task add_bcc(input logic [2:0] f, input int pos);
    logic [15:0] c;
    logic [7:0] s;
    int i;
    int b;
    c = stf_pkg::CRC_INIT;
    s = 8'h00;
    for (i = pos - 1; i < m.size(); i++)
    begin
      c = c ^ {8'h00, m[i]};
      for (b = 0; b < 8; b++)
        c = c[0] ? (c >> 1) ^ stf_pkg::CRC_POLY : c >> 1;
      if (f == stf_pkg::B_XOR)
        s = s ^ m[i];
      else if (f != stf_pkg::B_MASC)
        s = s + m[i];
      else if ((i - pos) % 2 == 0)
        s = s + {nib(m[i - 1]) << 4 | nib(m[i])};
    end
    if (f == stf_pkg::B_ADD2 || f == stf_pkg::B_MASC)
      s = -s;
    m.push_back(f == stf_pkg::B_MRTU ? c[7:0] : hexch({8'h00, s} >> 4));
    m.push_back(f == stf_pkg::B_MRTU ? c[15:8] : hexch({8'h00, s}));
  endtask

  // Watchdog reckoned well beyond the longest sequence
  initial
  begin
    #640000;
    n_mismatch++;
    conclude();
  end

  initial
  begin
    void'($urandom(15));
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    rd(stf_pkg::A_CTRL, 32'h008);
    rd(8'h10, 32'h0);
    rd(stf_pkg::A_STAT1, 32'h0);
    // Message on port one, seven data bits, check at position 1 by XOR
    wr(8'h40, 32'h010C);
    wr(8'h41, 32'h000C);
    wr(8'h42, 32'h0022);
    wr(8'h80, el(stf_pkg::K_CONST, 2'h0, 3'h0, 7'h00, 8'hC1));
    wr(8'h81, el(stf_pkg::K_WORD, stf_pkg::CV_BIN, 3'h2, 7'h01, 8'h00));
    wr(8'h82, el(stf_pkg::K_WORD, stf_pkg::CV_BCD, 3'h3, 7'h01, 8'h00));
    wr(8'h83, el(stf_pkg::K_WORD, stf_pkg::CV_BCD, 3'h2, 7'h02, 8'h01));
    wr(8'h84, el(stf_pkg::K_WORD, stf_pkg::CV_NONE, 3'h2, 7'h01, 8'h00));
    wr(8'h85, el(stf_pkg::K_BCC, stf_pkg::CV_BIN, 3'h2, 7'h00, 8'h00));
    wr(8'h86, el(stf_pkg::K_END, 2'h0, 3'h0, 7'h00, 8'h00));
    m = {8'h41};
    add_word(16'h010C, stf_pkg::CV_BIN, 2);
    add_word(16'h010C, stf_pkg::CV_BCD, 3);
    add_word(16'h000C, stf_pkg::CV_BCD, 2);
    add_word(16'h0022, stf_pkg::CV_BCD, 2);
    add_word(16'h010C, stf_pkg::CV_NONE, 2);
    add_bcc(stf_pkg::B_XOR, 1);
    foreach (m[i]) q1.push_back(m[i]);
    tick(1'b1, 1'b0, 1'b0, 2);
    rd(stf_pkg::A_STAT1, 32'h10);
    tick(1'b0, 1'b0, 1'b0, 1);
    rd(stf_pkg::A_STAT1, 32'h20);
    repeat (300) @(posedge clk);
    rd(stf_pkg::A_STAT1, 32'h30);
    tick(1'b0, 1'b0, 1'b0, 2);
    rd(stf_pkg::A_STAT1, 32'h40);
    rd(stf_pkg::A_CNT1, 32'(m.size()));
    wait_flag(1'b0);
    // Start from an interrupt routine is refused and flagged until cleared
    tick(1'b1, 1'b0, 1'b1, 3);
    check({30'h0, exec_error_relay, error_indicator}, 32'h3);
    rd(stf_pkg::A_ERR, 32'h1);
    wr(stf_pkg::A_CTRL, 32'h00C);
    rd(stf_pkg::A_ERR, 32'h0);
    // Held start while the terminal stalls: one run starts, five slots fill, the seventh start is refused
    hold_one <= 1'b1;
    for (k = 0; k < 7; k++)
      tick(1'b1, 1'b0, 1'b0, 3);
    rd(stf_pkg::A_STAT1, stf_pkg::ST_ERR_SLOT);
    repeat (6) foreach (m[i]) q1.push_back(m[i]);
    hold_one <= 1'b0;
    for (k = 0; k < 400 && q1.size() > 0; k++)
      tick(1'b0, 1'b0, 1'b0, 20);
    check(32'(q1.size()), 32'h0);
    check(32'(remote_terminal_inst.n_taken), 32'h62);
    // Long random message on port two is cut at 200 bytes
    m.delete();
    for (k = 0; k < 60; k++)
    begin
      rnd = $urandom;
      wr(8'h40 + 8'(k), {16'h0, rnd[15:0]});
      add_word(rnd[15:0], stf_pkg::CV_BIN, 4);
    end
    wr(8'h80, el(stf_pkg::K_WORD, stf_pkg::CV_BIN, 3'h4, 7'h3C, 8'h00));
    wr(8'h81, el(stf_pkg::K_END, 2'h0, 3'h0, 7'h00, 8'h00));
    while (m.size() > 200) void'(m.pop_back());
    foreach (m[i]) q2.push_back(m[i]);
    tick(1'b0, 1'b1, 1'b0, 2);
    wait_flag(1'b1);
    rd(stf_pkg::A_CNT2, 32'd200);
    // Every check formula, eight data bits on port two, range from position 2
    wr(8'h80, el(stf_pkg::K_CONST, 2'h0, 3'h0, 7'h00, 8'hC1));
    wr(8'h81, el(stf_pkg::K_CONST, 2'h0, 3'h0, 7'h00, 8'h31));
    wr(8'h82, el(stf_pkg::K_CONST, 2'h0, 3'h0, 7'h00, 8'h32));
    wr(8'h83, el(stf_pkg::K_CONST, 2'h0, 3'h0, 7'h00, 8'h41));
    wr(8'h84, el(stf_pkg::K_CONST, 2'h0, 3'h0, 7'h00, 8'h42));
    wr(8'h86, el(stf_pkg::K_END, 2'h0, 3'h0, 7'h00, 8'h00));
    for (int f = 0; f < 5; f++)
    begin
      // Let the two scans after the last completion pass, so the start clears the flag
      tick(1'b0, 1'b0, 1'b0, 2);
      tick(1'b0, 1'b0, 1'b0, 2);
      wr(stf_pkg::A_CTRL, {22'h0, 3'(f), 4'h2, 1'b0, 2'h2});
      wr(8'h85, el(stf_pkg::K_BCC, f == 4 ? stf_pkg::CV_NONE : stf_pkg::CV_BIN, 3'h2, 7'h0,
                   8'h00));
      m = {8'hC1, 8'h31, 8'h32, 8'h41, 8'h42};
      add_bcc(3'(f), 2);
      foreach (m[i]) q2.push_back(m[i]);
      tick(1'b0, 1'b1, 1'b0, 2);
      wait_flag(1'b1);
      rd(stf_pkg::A_CNT2, 32'h7);
    end
    repeat (4) @(posedge clk);
    conclude();
  end
endmodule
